//--- mfp_host_pins.sv
// Host side of the two pads: resolves each wire level from every driver
`timescale 1ns/10ps
module mfp_host_pins (
    input  wire logic       sys_clk,  // System clock
    input  wire logic [1:0] dev_out,  // Device drive values, pin one in bit 0
    input  wire logic [1:0] dev_oe,   // Device drive enables
    input  wire logic [1:0] host_en,  // Host drives the pad
    input  wire logic [1:0] host_val, // Host drive values
    input  wire logic       pull_up,  // Pin one pull-up on
    input  wire logic       pull_dn,  // Pin one pull-down on
    output logic      [1:0] pad       // Resolved pad levels
);
    logic [1:0] float_q = 2'h0;
    // An unpulled floating pad wanders
    always_ff @(posedge sys_clk) float_q <= ~pad;
    // Device wins over host; pulls only act on an undriven pin one
    assign pad[0] = dev_oe[0] ? dev_out[0] : host_en[0] ? host_val[0] : pull_up ? 1'b1 : pull_dn ? 1'b0 : float_q[0];
    assign pad[1] = dev_oe[1] ? dev_out[1] : host_en[1] ? host_val[1] : float_q[1];
endmodule

//--- mfp_multifunction_pin_and_irq.sv
// Two multi-function pins with interrupt capture, reached over AXI4-Lite
// Notes on behaviour
// - Pin one function code selects output source
// - Pin one pull-up bit5, pull-down bit4
// - Reset: pin one is IRQ, pull-down on
// - Pin four bit7: bit clock or general
// - General mode: bit clock from master pin
// - Pin four code decodes alike, resets input
// - Pin events only when configured as input
// - Sources: pins, extra inputs, lock, mic, sequencer
// - Status bit per source, always readable
// - Status latches until one written there
// - Masked sources latch, do not interrupt
// - Interrupt is OR of unmasked status
// - Interrupt holds until unmasked flags cleared
// - Per-source polarity inversion bit
// - Per-source selectable debounce filter
// - Status layout with summary at bit10
// - Mask bits reset to one
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
module mfp_multifunction_pin_and_irq #(
    parameter int DEBOUNCE_COUNT = mfp_pkg::DEBOUNCE_CYCLES  // Cycles an input must hold before it is believed
) (
    input  wire logic                     sys_clk,              // System clock, 100 MHz
    input  wire logic                     rst,                  // Asynchronous reset, active high
    input  wire mfp_pkg::mfp_axi_req_type axi_req,              // Register bus requests
    output mfp_pkg::mfp_axi_rsp_type      axi_rsp,              // Register bus answers
    input  wire mfp_pkg::mfp_core_type    core,                 // Internal clocks and status, same clock
    input  wire logic                     pin_one_in,           // Pin one level seen at the pad
    output logic                          pin_one_out,          // Pin one drive value
    output logic                          pin_one_oe,           // Pin one drive enable
    output logic                          pin1_pullup_en,       // Pin one pull-up resistor on
    output logic                          pin1_pulldown_en,     // Pin one pull-down resistor on
    input  wire logic                     pin_four_in,          // Pin four level seen at the pad
    output logic                          pin_four_out,         // Pin four drive value
    output logic                          pin_four_oe,          // Pin four drive enable
    input  wire logic                     extra_input_a,        // Dedicated input, asynchronous
    input  wire logic                     extra_input_b,        // Dedicated input, asynchronous
    output logic                          aif_bclk_from_master, // Audio bit clock taken from master clock pin
    output logic                          aif_bclk_master,      // Audio bit clock driven by the device
    output logic                          irq                   // Interrupt level, active high
);
    import mfp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration check
    if (DEBOUNCE_COUNT < 1 || DEBOUNCE_COUNT > 255) begin : g_bad_count
        $error("DEBOUNCE_COUNT must lie in 1..255");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State of the whole block
    typedef struct packed {
        logic [3:0]                  sync1;       // First synchroniser stage
        logic [3:0]                  sync2;       // Second synchroniser stage
        logic [15:0]                 pin1_control;
        logic [15:0]                 pin4_control;
        logic [15:0]                 aif_control;
        logic [SRC_W-1:0]            status;
        logic [SRC_W-1:0]            mask;
        logic [SRC_W-1:0]            polarity;
        logic [SRC_W-1:0]            debounce;
        logic [SRC_W-1:0]            filt;        // Debounced levels
        logic [SRC_W-1:0][7:0]       db_cnt;      // Per-source stability counters
        logic [SRC_W-1:0]            prev;        // Last conditioned level, for edges
        logic                        aw_got;
        logic [11:0]                 awaddr;
        logic                        w_got;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
        logic                        p1_out;
        logic                        p1_oe;
        logic                        p4_out;
        logic                        p4_oe;
        logic                        irq;
    } mfp_state_type;

    localparam mfp_state_type STATE_RESET = '{
        pin1_control : PIN1_RESET,
        pin4_control : PIN4_RESET,
        mask         : MASK_RESET[SRC_W-1:0],
        default      : '0
    };

    mfp_state_type state;
    mfp_state_type next_state;

    ////////////////////////////////////////////////////////////////////////////////
    // Shared function decode for both pins: returns {drive enable, value}
    function automatic logic [1:0] mfp_drive(input logic [3:0] sel, input mfp_core_type c, input logic irq_lvl);
        logic [1:0] res;
        res = 2'h0;
        case (sel)
            FN_INPUT:     res = 2'h0;
            FN_DIV_CLOCK: res = {1'b1, c.div_clock};
            FN_LOW:       res = 2'h2;
            FN_HIGH:      res = 2'h3;
            FN_IRQ:       res = {1'b1, irq_lvl};
            FN_LOCK:      res = {1'b1, c.lock};
            FN_MIC_DET:   res = {1'b1, c.mic_det};
            FN_MIC_SHORT: res = {1'b1, c.mic_short};
            FN_DIGITAL_MIC_CLOCK_CLK:  res = {1'b1, c.digital_mic_clock_clock};
            FN_OSC_CLK:   res = {1'b1, c.osc_clock};
            default:      res = 2'h0;          // Reserved codes leave the pin undriven
        endcase
        return res;
    endfunction

    // Merge masked byte lanes into a 16-bit register
    function automatic logic [15:0] mfp_merge(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb, input logic [15:0] wmask);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res & wmask;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Combinational wiring
    logic [SRC_W-1:0] raw;
    logic [SRC_W-1:0] cond;
    logic [SRC_W-1:0] live;
    logic [SRC_W-1:0] src_en;
    logic [SRC_W-1:0] set_ev;
    logic [SRC_W-1:0] clr;
    logic             aw_hs;
    logic             w_hs;
    logic             ar_hs;
    logic             do_write;
    logic [11:0]      wr_addr;
    logic [31:0]      wr_data;
    logic [3:0]       wr_strb;
    logic [31:0]      rd_val;
    logic             rd_hit;
    logic             wr_hit;
    logic             pin4_general;
    logic [1:0]       drv1;
    logic [1:0]       drv4;

    // Handshake outputs follow the pending flags directly
    assign aw_hs = axi_req.awvalid && !state.aw_got && !state.bvalid;
    assign w_hs  = axi_req.wvalid && !state.w_got && !state.bvalid;
    assign ar_hs = axi_req.arvalid && !state.rvalid;
    // Write goes ahead once both halves are held, in either order
    assign do_write = (state.aw_got || aw_hs) && (state.w_got || w_hs) && !state.bvalid;
    assign wr_addr  = state.aw_got ? state.awaddr : axi_req.awaddr;
    assign wr_data  = state.w_got ? state.wdata : axi_req.wdata;
    assign wr_strb  = state.w_got ? state.wstrb : axi_req.wstrb;

    assign pin4_general = state.pin4_control[PIN4_MODE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode; misaligned or unknown addresses answer with an error
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = (axi_req.araddr[1:0] == 2'h0);
        case (axi_req.araddr[11:2])
            IDX_PIN1_CONTROL: rd_val[15:0] = state.pin1_control;
            IDX_PIN4_CONTROL: rd_val[15:0] = state.pin4_control;
            IDX_AIF_CONTROL:  rd_val[15:0] = state.aif_control;
            IDX_IRQ_STATUS: begin
                rd_val[SRC_W-1:0]      = state.status;
                rd_val[IRQ_SUMMARY_BIT] = |state.status;
            end
            IDX_IRQ_MASK:     rd_val[SRC_W-1:0] = state.mask;
            IDX_IRQ_POLARITY: rd_val[SRC_W-1:0] = state.polarity;
            IDX_IRQ_DEBOUNCE: rd_val[SRC_W-1:0] = state.debounce;
            default:          rd_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt source conditioning
    always_comb begin
        // pins read only after second stage
        raw                = '0;
        raw[SRC_MIC_DET]   = core.mic_det;
        raw[SRC_MIC_SHORT] = core.mic_short;
        raw[SRC_LOCK]      = core.lock;
        raw[SRC_EXTRA_A]   = state.sync2[2];
        raw[SRC_EXTRA_B]   = state.sync2[3];
        raw[SRC_PIN_ONE]   = state.sync2[0];
        raw[SRC_WSEQ]      = core.wseq_done;
        raw[SRC_PIN_FOUR]  = state.sync2[1];
        src_en               = SRC_BITS[SRC_W-1:0];
        src_en[SRC_PIN_ONE]  = (state.pin1_control[3:0] == FN_INPUT);
        src_en[SRC_PIN_FOUR] = pin4_general && (state.pin4_control[3:0] == FN_INPUT);
        cond = raw ^ state.polarity;
        // debounced level replaces cond when selected
        live = ((state.debounce & state.filt) | (~state.debounce & cond)) & src_en;
        // Capture on the rising edge of the conditioned level
        set_ev = live & ~state.prev;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_state = state;
        clr        = '0;
        wr_hit     = (wr_addr[1:0] == 2'h0);

        next_state.sync1 = {extra_input_b, extra_input_a, pin_four_in, pin_one_in};
        next_state.sync2 = state.sync1;

        for (int i = 0; i < SRC_W; i++) begin
            if (cond[i] == state.filt[i]) begin
                next_state.db_cnt[i] = 8'h00;
            end else if (state.db_cnt[i] == 8'(DEBOUNCE_COUNT - 1)) begin
                next_state.filt[i]   = cond[i];
                next_state.db_cnt[i] = 8'h00;
            end else begin
                next_state.db_cnt[i] = state.db_cnt[i] + 8'h01;
            end
        end
        next_state.prev = live;

        // Write address and data may arrive separately
        if (aw_hs) begin
            next_state.aw_got = 1'b1;
            next_state.awaddr = axi_req.awaddr;
        end
        if (w_hs) begin
            next_state.w_got = 1'b1;
            next_state.wdata = axi_req.wdata;
            next_state.wstrb = axi_req.wstrb;
        end
        if (do_write) begin
            next_state.aw_got = 1'b0;
            next_state.w_got  = 1'b0;
            next_state.bvalid = 1'b1;
            case (wr_addr[11:2])
                IDX_PIN1_CONTROL: next_state.pin1_control = mfp_merge(state.pin1_control, wr_data, wr_strb,
                                                                      PIN1_WR_MASK);
                IDX_PIN4_CONTROL: next_state.pin4_control = mfp_merge(state.pin4_control, wr_data, wr_strb,
                                                                      PIN4_WR_MASK);
                IDX_AIF_CONTROL:  next_state.aif_control = mfp_merge(state.aif_control, wr_data, wr_strb,
                                                                     AIF_WR_MASK);
                IDX_IRQ_STATUS: begin
                    // Each strobed lane clears its own flags; unstrobed lanes clear none
                    clr = wr_data[SRC_W-1:0];
                    if (!wr_strb[0]) begin
                        clr[7:0] = '0;
                    end
                    if (!wr_strb[1]) begin
                        clr[SRC_W-1:8] = '0;
                    end
                end
                IDX_IRQ_MASK:     next_state.mask = SRC_W'(mfp_merge({6'h00, state.mask}, wr_data, wr_strb,
                                                              SRC_BITS));
                IDX_IRQ_POLARITY: next_state.polarity = SRC_W'(mfp_merge({6'h00, state.polarity}, wr_data, wr_strb,
                                                                  SRC_BITS));
                IDX_IRQ_DEBOUNCE: next_state.debounce = SRC_W'(mfp_merge({6'h00, state.debounce}, wr_data, wr_strb,
                                                                  SRC_BITS));
                default:          wr_hit = 1'b0;
            endcase
            next_state.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (state.bvalid && axi_req.bready) begin
            next_state.bvalid = 1'b0;
        end

        // Read answer one cycle after the address is taken
        if (ar_hs) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = rd_val;
            next_state.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (state.rvalid && axi_req.rready) begin
            next_state.rvalid = 1'b0;
        end

        // new event wins over a clear in the same cycle
        next_state.status = ((state.status & ~clr) | set_ev) & SRC_BITS[SRC_W-1:0];

        // level holds until those flags clear
        next_state.irq = |(next_state.status & ~next_state.mask);

        // pin one output from its function code
        drv1               = mfp_drive(state.pin1_control[3:0], core, state.irq);
        next_state.p1_oe   = drv1[1];
        next_state.p1_out  = drv1[0];

        // no bit clock drive in general mode
        if (pin4_general) begin
            drv4 = mfp_drive(state.pin4_control[3:0], core, state.irq);
        end else begin
            drv4 = {state.aif_control[AIF_BCLK_DIR_BIT], core.aif_bclk_gen};
        end
        next_state.p4_oe  = drv4[1];
        next_state.p4_out = drv4[0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    // reset selects interrupt output, pull-down on
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign axi_rsp.awready  = !state.aw_got && !state.bvalid;
    assign axi_rsp.wready   = !state.w_got && !state.bvalid;
    assign axi_rsp.bvalid   = state.bvalid;
    assign axi_rsp.bresp    = state.bresp;
    assign axi_rsp.arready  = !state.rvalid;
    assign axi_rsp.rvalid   = state.rvalid;
    assign axi_rsp.rdata    = state.rdata;
    assign axi_rsp.rresp    = state.rresp;
    assign pin_one_out      = state.p1_out;
    assign pin_one_oe       = state.p1_oe;
    // resistor enables straight from their bits
    assign pin1_pullup_en   = state.pin1_control[PIN1_PULLUP_BIT];
    assign pin1_pulldown_en = state.pin1_control[PIN1_PULLDOWN_BIT];
    assign pin_four_out     = state.p4_out;
    assign pin_four_oe      = state.p4_oe;
    // master clock pin feeds the bit clock in general mode
    assign aif_bclk_from_master = pin4_general;
    // Direction is forced to slave in general mode; software should also clear it
    assign aif_bclk_master  = state.aif_control[AIF_BCLK_DIR_BIT] && !pin4_general;
    assign irq              = state.irq;

endmodule

//--- mfp_pkg.sv
// Package: register map, field layout, reset values and carrier types for the multi-function pin block
package mfp_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [9:0] IDX_PIN1_CONTROL = 10'h079;
    localparam logic [9:0] IDX_PIN4_CONTROL = 10'h07C;
    localparam logic [9:0] IDX_IRQ_STATUS   = 10'h07F;
    localparam logic [9:0] IDX_IRQ_MASK     = 10'h080;
    localparam logic [9:0] IDX_IRQ_POLARITY = 10'h081;
    localparam logic [9:0] IDX_IRQ_DEBOUNCE = 10'h082;
    localparam logic [9:0] IDX_AIF_CONTROL  = 10'h083;

    // Field positions
    localparam int PIN1_PULLUP_BIT   = 5;
    localparam int PIN1_PULLDOWN_BIT = 4;
    localparam int PIN4_MODE_BIT     = 7;
    localparam int AIF_BCLK_DIR_BIT  = 0;
    localparam int IRQ_SUMMARY_BIT   = 10;
    localparam int SRC_MIC_DET       = 0;
    localparam int SRC_MIC_SHORT     = 1;
    localparam int SRC_LOCK          = 2;
    localparam int SRC_EXTRA_A       = 3;
    localparam int SRC_EXTRA_B       = 4;
    localparam int SRC_PIN_ONE       = 5;
    localparam int SRC_WSEQ          = 8;
    localparam int SRC_PIN_FOUR      = 9;
    localparam int SRC_W             = 10;

    // Writable bits of each register and reset values
    localparam logic [15:0] PIN1_WR_MASK   = 16'h003F;
    localparam logic [15:0] PIN4_WR_MASK   = 16'h008F;
    localparam logic [15:0] SRC_BITS       = 16'h033F;
    localparam logic [15:0] AIF_WR_MASK    = 16'h0001;
    localparam logic [15:0] PIN1_RESET     = 16'h0014;
    localparam logic [15:0] PIN4_RESET     = 16'h0000;
    localparam logic [15:0] MASK_RESET     = 16'h033F;

    // Debounce settling time and its cycle count at 100 MHz
    localparam int CLK_PERIOD_NS   = 10;
    localparam int DEBOUNCE_NS     = 1000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin function codes, shared by both pins
    typedef enum logic [3:0] {
        FN_INPUT     = 4'h0,
        FN_DIV_CLOCK = 4'h1,
        FN_LOW       = 4'h2,
        FN_HIGH      = 4'h3,
        FN_IRQ       = 4'h4,
        FN_LOCK      = 4'h5,
        FN_MIC_DET   = 4'h6,
        FN_MIC_SHORT = 4'h7,
        FN_DIGITAL_MIC_CLOCK_CLK  = 4'h8,
        FN_OSC_CLK   = 4'h9
    } mfp_func_type;

    // Bus master to slave
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } mfp_axi_req_type;

    // Slave to bus master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mfp_axi_rsp_type;

    // Internal signals offered to the pins and to the interrupt logic
    typedef struct packed {
        logic div_clock;
        logic osc_clock;
        logic digital_mic_clock_clock;
        logic lock;
        logic mic_det;
        logic mic_short;
        logic wseq_done;
        logic aif_bclk_gen;
    } mfp_core_type;

endpackage

//--- mfp_properties.sv
// Checker: bus, bit clock and interrupt properties
`timescale 1ns/10ps
module mfp_properties (
    input wire logic                     sys_clk,              // System clock
    input wire logic                     rst,                  // Reset, active high
    input wire mfp_pkg::mfp_axi_req_type axi_req,              // Bus requests
    input wire mfp_pkg::mfp_axi_rsp_type axi_rsp,              // Bus answers
    input wire mfp_pkg::mfp_core_type    core,                 // Core sources
    input wire logic                     pin1_pullup_en,       // Pin one pull-up
    input wire logic                     pin1_pulldown_en,     // Pin one pull-down
    input wire logic                     pin_four_out,         // Pin four drive value
    input wire logic                     pin_four_oe,          // Pin four drive enable
    input wire logic                     aif_bclk_from_master, // Bit clock from master pin
    input wire logic                     aif_bclk_master,      // Bit clock driven by device
    input wire logic                     irq                   // Interrupt level
);
    import mfp_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Write taken whole; status read taken
    sequence s_wr;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_st_rd;
        axi_req.arvalid && axi_rsp.arready && axi_req.araddr == {IDX_IRQ_STATUS, 2'h0};
    endsequence
    AST_RESET_PULLS:
        assert property ($fell(rst) |-> pin1_pulldown_en && !pin1_pullup_en) else $error("pull reset wrong");
    AST_WR_ANSWER:
        assert property (s_wr |=> axi_rsp.bvalid) else $error("no write answer");
    AST_B_ONCE:
        assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid) else $error("bvalid stuck");
    AST_RD_ANSWER:
        assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("no read answer");
    AST_SUMMARY:
        assert property (s_st_rd |=> axi_rsp.rdata[10] == (|axi_rsp.rdata[9:0])) else $error("summary bit wrong");
    AST_IRQ_FLAG:
        assert property (s_st_rd ##0 irq |=> axi_rsp.rdata[10]) else $error("irq without flag");
    AST_IRQ_FALL:
        assert property ($fell(irq) |-> axi_rsp.bvalid || $past(axi_rsp.bvalid)) else $error("irq fell alone");
    AST_BCLK_ONE:
        assert property (aif_bclk_from_master |-> !aif_bclk_master) else $error("bit clock driven");
    AST_BCLK_PIN:
        assert property (!aif_bclk_from_master [*2] |-> pin_four_oe == $past(aif_bclk_master)
            && (!pin_four_oe || pin_four_out == $past(core.aif_bclk_gen))) else $error("bit clock pin wrong");
endmodule
bind mfp_multifunction_pin_and_irq mfp_properties u_props (
    .sys_clk, .rst, .axi_req, .axi_rsp, .core, .pin1_pullup_en, .pin1_pulldown_en,
    .pin_four_out, .pin_four_oe, .aif_bclk_from_master, .aif_bclk_master, .irq);

//--- tb.sv
// Bench: register bus, pins and interrupts
`timescale 1ns/10ps
module tb;
    import mfp_pkg::*;
    localparam logic [11:0] A_P1 = {IDX_PIN1_CONTROL, 2'h0}, A_P4 = {IDX_PIN4_CONTROL, 2'h0},
        A_ST = {IDX_IRQ_STATUS, 2'h0}, A_MK = {IDX_IRQ_MASK, 2'h0}, A_PL = {IDX_IRQ_POLARITY, 2'h0},
        A_DB = {IDX_IRQ_DEBOUNCE, 2'h0}, A_AIF = {IDX_AIF_CONTROL, 2'h0};
    localparam logic [15:0] EXP_OUT = 16'h0148; // Level per code
    logic sys_clk = 0;
    logic rst = 1;
    mfp_axi_req_type req = '0;
    mfp_axi_rsp_type rsp;
    mfp_core_type core = '0;
    logic [1:0] dev_out, dev_oe, pad;
    logic [1:0] host_val = 2'h0;
    logic pu, pd, fm, bm, irq;
    logic exa = 0;
    logic exb = 0;
    int fails = 0;
    int check_count = 0;
    mfp_multifunction_pin_and_irq #(.DEBOUNCE_COUNT(2)) u_dut (.sys_clk, .rst, .axi_req(req), .axi_rsp(rsp),
        .core, .pin_one_in(pad[0]), .pin_one_out(dev_out[0]), .pin_one_oe(dev_oe[0]), .pin1_pullup_en(pu),
        .pin1_pulldown_en(pd), .pin_four_in(pad[1]), .pin_four_out(dev_out[1]), .pin_four_oe(dev_oe[1]),
        .extra_input_a(exa), .extra_input_b(exb), .aif_bclk_from_master(fm), .aif_bclk_master(bm), .irq);
    mfp_host_pins u_host (.sys_clk, .dev_out, .dev_oe, .host_en(2'h3), .host_val, .pull_up(pu),
        .pull_dn(pd), .pad);
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Ready sampled mid-cycle
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic aw, w, b;
        logic [1:0] r;
        int n;
        @(posedge sys_clk);
        req.awvalid <= 1; req.awaddr <= a; req.wvalid <= 1;
        req.wdata <= {16'h0, d}; req.wstrb <= 4'h3; req.bready <= 1;
        {aw, w, b, n} = '0;
        while (!b && n < 50) begin
            @(negedge sys_clk);
            aw = aw | rsp.awready; w = w | rsp.wready; b = rsp.bvalid; r = rsp.bresp;
            @(posedge sys_clk);
            if (aw) req.awvalid <= 0;
            if (w) req.wvalid <= 0;
            n++;
        end
        req.bready <= 0;
        chk("bresp", {14'h0, RESP_OKAY}, {b, 13'h0, r} ^ 16'h8000);
    endtask
    task automatic rd(input logic [11:0] a, output logic [15:0] d, output logic [1:0] r);
        logic ar, b;
        int n;
        @(posedge sys_clk);
        req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
        {ar, b, n} = '0;
        while (!b && n < 50) begin
            @(negedge sys_clk);
            ar = ar | rsp.arready; b = rsp.rvalid; d = rsp.rdata[15:0]; r = rsp.rresp;
            @(posedge sys_clk);
            if (ar) req.arvalid <= 0;
            n++;
        end
        req.rready <= 0;
        if (!b) fails++;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [15:0] e);
        logic [15:0] v;
        logic [1:0] q;
        rd(a, v, q);
        chk("rdata", e, v);
        chk("rresp", {14'h0, RESP_OKAY}, {14'h0, q});
    endtask
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence; static core levels
    initial begin
        logic [15:0] v;
        logic [1:0] q;
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        rdc(A_P1, PIN1_RESET);
        rdc(A_P4, PIN4_RESET);
        rdc(A_MK, MASK_RESET);
        chk("pd", 1, pd);
        chk("pu", 0, pu);
        rd(12'h300, v, q);
        chk("unmapped", {14'h0, RESP_SLVERR}, {14'h0, q});
        core <= 8'h28;
        wr(A_AIF, 16'h0001);
        wt(2);
        chk("bm", 1, bm);
        chk("oe4", 1, dev_oe[1]);
        wr(A_P4, 16'h0080);
        wt(2);
        chk("bm", 0, bm);
        chk("fm", 1, fm);
        wr(A_AIF, 16'h0000);
        for (int c = 0; c < 11; c++) begin
            wr(A_P1, {10'h0, c[1:0], c[3:0]});
            wr(A_P4, {8'h0, 4'h8, c[3:0]});
            wt(2);
            rdc(A_P1, {10'h0, c[1:0], c[3:0]});
            chk("pu", c[1], pu);
            chk("pd", c[0], pd);
            chk("oe1", (c > 0 && c < 10), dev_oe[0]);
            chk("oe4", (c > 0 && c < 10), dev_oe[1]);
            if (c > 0 && c < 10) chk("out1", EXP_OUT[c], dev_out[0]);
            if (c > 0 && c < 10) chk("out4", EXP_OUT[c], dev_out[1]);
        end
        rdc(A_ST, 16'h0401);
        chk("irq", 0, irq);
        rdc(A_ST, 16'h0401);
        wr(A_ST, 16'h0001);
        rdc(A_ST, 16'h0000);
        wr(A_P1, 16'h0014);
        wr(A_MK, 16'h033B);
        core.lock <= 1;
        wt(4);
        chk("irq", 1, irq);
        chk("out1", 1, dev_out[0]);
        rdc(A_ST, 16'h0404);
        wr(A_ST, 16'h0001);
        wt(1);
        chk("irq", 1, irq);
        wr(A_ST, 16'h0004);
        wt(2);
        chk("irq", 0, irq);
        wr(A_PL, 16'h0002);
        wt(3);
        rdc(A_ST, 16'h0402);
        wr(A_DB, 16'h0008);
        exa <= 1;
        @(posedge sys_clk) exa <= 0;
        wt(8);
        rdc(A_ST, 16'h0402);
        exa <= 1;
        wt(10);
        rdc(A_ST, 16'h040A);
        host_val[1] <= 1;
        wt(6);
        rdc(A_ST, 16'h040A);
        host_val[1] <= 0;
        wr(A_P4, 16'h0080);
        wt(6);
        host_val[1] <= 1;
        core.wseq_done <= 1;
        wt(6);
        rdc(A_ST, 16'h070A);
        summarize();
    end
    // Watchdog, far beyond the sequence
    initial begin
        #300000;
        fails++;
        summarize();
    end
endmodule
